// [dv/ext_memory_model.sv]
// Behavioural static memory on the far side of the pins
`timescale 1ns/10ps
module ext_memory_model (
   input  wire logic                             core_clk_in,
   input  wire logic                             read_strobe_n_in,
   input  wire logic                             write_strobe_n_in,
   input  wire logic                             data_oe_in,
   input  wire logic [smc_pin_pkg::ADDR_W-1:0]   addr_in,
   input  wire logic [smc_pin_pkg::DATA_W-1:0]   data_in,
   input  wire logic [7:0]                       stall_in,
   output logic [smc_pin_pkg::DATA_W-1:0]        data_out,
   output logic                                  wait_n_out,
   output logic [smc_pin_pkg::DATA_W-1:0]        wdata_out
);
   logic [7:0]  stall_cnt_r = 8'h00;
   logic        rd_d_r      = 1'b1;
   logic [31:0] last_r      = 32'h0000_0000;
   // Released bus toggles so a stale word never passes for a read
   assign data_out   = !read_strobe_n_in ? {8'h2d, addr_in[25:2]} : ~last_r;
   // Wait drops as the strobe falls, so it clears the pin synchroniser in time
   assign wait_n_out = (stall_cnt_r == 8'h00) &&
                       !(rd_d_r && !read_strobe_n_in && stall_in != 8'h00);
   // Flash chip enable is left to general I/O, held active here
   always @(posedge core_clk_in) begin
      rd_d_r <= read_strobe_n_in;
      last_r <= data_out;
      if (rd_d_r && !read_strobe_n_in && stall_in != 8'h00)
         stall_cnt_r <= stall_in;
      else if (stall_cnt_r != 8'h00)
         stall_cnt_r <= stall_cnt_r - 8'h01;
      if (!write_strobe_n_in && data_oe_in)
         wdata_out <= data_in;
   end
endmodule : ext_memory_model

// [dv/smc_pin_monitor.sv]
// Port-level assertions for the static memory pin interface
`timescale 1ns/10ps
module smc_pin_monitor (
   input wire logic                            core_clk_in,
   input wire logic                            rst_n_in,
   input wire logic                            req_ready_out,
   input wire logic                            rdata_valid_out,
   input wire logic                            flash_region_assign_in,
   input wire logic                            card_assign_in,
   input wire logic                            slow_clock_in,
   input wire logic                            wait_request_n_in,
   input wire logic [smc_pin_pkg::NUM_CS-1:0]  chip_select_n_out,
   input wire logic                            card_slot_select_out,
   input wire logic                            card_direction_out,
   input wire logic                            read_strobe_n_out,
   input wire logic                            write_strobe_n_out,
   input wire logic                            flash_output_enable_out,
   input wire logic                            flash_write_enable_out,
   input wire logic                            flash_ale_out,
   input wire logic                            flash_cle_out,
   input wire logic [smc_pin_pkg::ADDR_W-1:0]  addr_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);

   chk_card_mirror: assert property (card_assign_in |->
      card_slot_select_out == chip_select_n_out[4]) else $error("card select mismatch");
   chk_dir_stable: assert property (!req_ready_out && $past(!req_ready_out) |->
      $stable(card_direction_out)) else $error("direction moved mid transfer");
   chk_flash_read: assert property (flash_region_assign_in && !chip_select_n_out[3] |->
      flash_output_enable_out == read_strobe_n_out) else $error("flash read enable wrong");
   chk_flash_write: assert property (flash_region_assign_in && !chip_select_n_out[3] |->
      flash_write_enable_out == write_strobe_n_out) else $error("flash write enable wrong");
   chk_flash_idle: assert property (chip_select_n_out[3] |->
      flash_output_enable_out && flash_write_enable_out) else $error("flash enable outside");
   chk_shared_pins: assert property (flash_region_assign_in |->
      chip_select_n_out[7:6] == {flash_write_enable_out, flash_output_enable_out})
      else $error("shared select pins wrong");
   chk_latch_bits: assert property ({flash_ale_out, flash_cle_out} == addr_out[22:21])
      else $error("latch enables not from address");
   chk_idle_high: assert property (req_ready_out |-> chip_select_n_out == 8'hff &&
      read_strobe_n_out && write_strobe_n_out) else $error("strobe active while idle");
   chk_wait_hold: assert property ((!wait_request_n_in)[*5] ##0 !read_strobe_n_out
      |=> !read_strobe_n_out) else $error("read ended under wait");
   chk_slow_pulse: assert property (slow_clock_in && wait_request_n_in &&
      $fell(read_strobe_n_out) |=> !read_strobe_n_out ##1 read_strobe_n_out)
      else $error("slow read pulse length wrong");

   cov_flash_read: cover property (!chip_select_n_out[3] && !flash_output_enable_out);
   cov_card_write: cover property (!card_slot_select_out && !card_direction_out);
   cov_stall: cover property (!wait_request_n_in && !read_strobe_n_out);
   cov_burst: cover property (rdata_valid_out ##[1:8] rdata_valid_out);
endmodule : smc_pin_monitor

// [dv/static_memory_pin_interface_tb.sv]
// Self-checking bench for the static memory pin interface
`timescale 1ns/10ps
module static_memory_pin_interface_tb;
   logic                              core_clk_in = 1'b0;
   logic                              rst_n_in    = 1'b0;
   smc_pin_pkg::access_req_s          req;
   smc_pin_pkg::per_select_mode_s [7:0] mode;
   logic        flash_asg, card_asg, slow, wait_n, ready, rvalid, done, oe;
   logic        card_sel, card_dir, rd_n, wr_n, l0, l1, l2, l3, foe_n, fwe_n, ale, cle;
   logic [7:0]  cs_n, stall;
   logic [25:0] a;
   logic [31:0] din, dout, rdata, wseen;
   int          failures = 0;
   int          n_checks = 0;

   always #5 core_clk_in = ~core_clk_in;

   static_memory_pin_interface dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .req_in(req), .req_ready_out(ready), .rdata_valid_out(rvalid), .rdata_out(rdata),
      .done_out(done), .mode_in(mode), .flash_region_assign_in(flash_asg),
      .card_assign_in(card_asg), .slow_clock_in(slow), .wait_request_n_in(wait_n),
      .chip_select_n_out(cs_n), .card_slot_select_out(card_sel),
      .card_direction_out(card_dir), .read_strobe_n_out(rd_n), .write_strobe_n_out(wr_n),
      .lane0_out(l0), .lane1_out(l1), .lane2_out(l2), .lane3_out(l3),
      .flash_output_enable_out(foe_n), .flash_write_enable_out(fwe_n),
      .flash_ale_out(ale), .flash_cle_out(cle), .addr_out(a), .data_in(din),
      .data_out(dout), .data_oe_out(oe));

   ext_memory_model mem (.core_clk_in(core_clk_in), .read_strobe_n_in(rd_n),
      .write_strobe_n_in(wr_n), .data_oe_in(oe), .addr_in(a), .data_in(dout),
      .stall_in(stall), .data_out(din), .wait_n_out(wait_n), .wdata_out(wseen));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic test_done();
      if (failures == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done

   task automatic set_mode(input int i, input smc_pin_pkg::bus_width_e w,
                           input smc_pin_pkg::byte_access_e b, input logic [5:0] s,
                           input logic [5:0] p, input logic [5:0] h);
      mode[i] = '{w, b, s, p, h};
   endtask : set_mode

   // One whole access; pins are folded so any low (or high) moment is seen
   task automatic run(input logic [2:0] cs, input logic w, input logic [25:0] ad,
                      input logic [3:0] be, input logic [7:0] ep, input logic [7:0] em,
                      input logic [3:0] ef, input logic [4:0] len, input logic [7:0] stl);
      logic [7:0]  scs;
      logic [7:0]  spin;
      logic [7:0]  ecs;
      logic [3:0]  sfl;
      logic [31:0] q[$];
      int          n;
      int          dexp;
      @(posedge core_clk_in);
      #1;
      stall = stl;
      req   = '{1'b1, w, cs, ad, be, {ad[15:0], 16'hc3a5}, len != 5'h00, len};
      n = 0;
      while (!ready && n < 100) begin
         @(posedge core_clk_in);
         #1;
         n++;
      end
      if (!ready) begin
         failures++;
         test_done();
      end
      @(posedge core_clk_in);
      #1;
      req.valid = 1'b0;
      scs  = 8'hff;
      spin = 8'hff;
      sfl  = 4'h3;
      n    = 0;
      while (n < 400) begin
         n++;
         scs  &= cs_n;
         spin &= {l3, l2, l1, l0, wr_n, rd_n, card_sel, card_dir};
         sfl   = {sfl[3] | ale, sfl[2] | cle, sfl[1] & fwe_n, sfl[0] & foe_n};
         if (rvalid === 1'b1) q.push_back(rdata);
         if (done === 1'b1) break;
         @(posedge core_clk_in);
         #1;
      end
      if (done !== 1'b1) begin
         failures++;
         test_done();
      end
      ecs = ~(8'h01 << cs);
      if (flash_asg && cs == 3'h3) ecs &= w ? 8'h7f : 8'hbf;
      dexp = slow ? 7 : mode[cs].setup + mode[cs].pulse + mode[cs].hold + 4;
      check("selects", scs, ecs);
      check("pins", spin & em, ep & em);
      check("flash", {28'h0, sfl}, {28'h0, ef});
      if (len == 5'h00 && stl == 8'h00) check("cycles", 32'(n), 32'(dexp));
      if (stl != 8'h00) check("stretch", 32'(n >= dexp + 8), 32'h1);
      if (w) check("wdata", wseen, {ad[15:0], 16'hc3a5});
      if (!w && cs == 3'h5) begin
         check("beats", 32'(q.size()), 32'(len) + 32'h1);
         foreach (q[i]) check("rdata", q[i], {8'h2d, 24'(ad[25:2] + i)});
      end
   endtask : run

   initial begin
      req       = '0;
      stall     = 8'h00;
      flash_asg = 1'b0;
      card_asg  = 1'b1;
      slow      = 1'b0;
      mode      = '0;
      for (int i = 0; i < 8; i++) set_mode(i, smc_pin_pkg::WIDTH_8, smc_pin_pkg::BYTE_SELECT,
                                           6'h01, 6'h02, 6'h01);
      set_mode(1, smc_pin_pkg::WIDTH_16, smc_pin_pkg::BYTE_SELECT, 6'h00, 6'h01, 6'h00);
      set_mode(2, smc_pin_pkg::WIDTH_32, smc_pin_pkg::BYTE_WRITE, 6'h02, 6'h01, 6'h02);
      set_mode(4, smc_pin_pkg::WIDTH_16, smc_pin_pkg::BYTE_SELECT, 6'h01, 6'h03, 6'h01);
      set_mode(5, smc_pin_pkg::WIDTH_32, smc_pin_pkg::BYTE_SELECT, 6'h03, 6'h04, 6'h02);
      repeat (2) @(posedge core_clk_in);
      #1;
      rst_n_in = 1'b1;
      check("idle selects", {24'h0, cs_n}, 32'h0000_00ff);
      check("idle strobes", {29'h0, rd_n, wr_n, ready}, 32'h0000_0007);
      run(3'h0, 1'b0, 26'h0000002, 4'hf, 8'h4b, 8'h5f, 4'h3, 5'h00, 8'h00);
      run(3'h1, 1'b1, 26'h0000010, 4'h2, 8'h16, 8'h7e, 4'h3, 5'h00, 8'h00);
      run(3'h2, 1'b1, 26'h0000100, 4'h5, 8'hb6, 8'hfe, 4'h3, 5'h00, 8'h00);
      run(3'h5, 1'b0, 26'h0000204, 4'hf, 8'h0a, 8'hfe, 4'h3, 5'h00, 8'h00);
      run(3'h4, 1'b0, 26'h0000008, 4'h3, 8'h09, 8'h7f, 4'h3, 5'h00, 8'h00);
      run(3'h4, 1'b1, 26'h000000a, 4'h1, 8'h64, 8'h7f, 4'h3, 5'h00, 8'h00);
      run(3'h6, 1'b0, 26'h3fffffc, 4'hf, 8'h0b, 8'h5f, 4'hf, 5'h00, 8'h00);
      run(3'h5, 1'b0, 26'h0000020, 4'hf, 8'h0a, 8'hfe, 4'h3, 5'h07, 8'h00);
      run(3'h5, 1'b0, 26'h0000040, 4'hf, 8'h0a, 8'hfe, 4'h3, 5'h00, 8'h0c);
      slow = 1'b1;
      run(3'h5, 1'b0, 26'h0000080, 4'hf, 8'h0a, 8'hfe, 4'h3, 5'h00, 8'h00);
      slow      = 1'b0;
      flash_asg = 1'b1;
      // Sixth and seventh regions stay untouched while flash owns their pins
      run(3'h3, 1'b0, 26'h0400000, 4'hf, 8'h0b, 8'h5f, 4'ha, 5'h00, 8'h00);
      run(3'h3, 1'b1, 26'h0200000, 4'h1, 8'h06, 8'h5e, 4'h5, 5'h00, 8'h00);
      run(3'h0, 1'b0, 26'h0000000, 4'hf, 8'h0b, 8'h5f, 4'h3, 5'h00, 8'h00);
      test_done();
   end
endmodule : static_memory_pin_interface_tb

bind static_memory_pin_interface smc_pin_monitor u_mon (.core_clk_in(core_clk_in),
   .rst_n_in(rst_n_in), .req_ready_out(req_ready_out), .rdata_valid_out(rdata_valid_out),
   .flash_region_assign_in(flash_region_assign_in), .card_assign_in(card_assign_in),
   .slow_clock_in(slow_clock_in), .wait_request_n_in(wait_request_n_in),
   .chip_select_n_out(chip_select_n_out), .card_slot_select_out(card_slot_select_out),
   .card_direction_out(card_direction_out), .read_strobe_n_out(read_strobe_n_out),
   .write_strobe_n_out(write_strobe_n_out), .flash_output_enable_out(flash_output_enable_out),
   .flash_write_enable_out(flash_write_enable_out), .flash_ale_out(flash_ale_out),
   .flash_cle_out(flash_cle_out), .addr_out(addr_out));

// [rtl/pin_mux.sv]
// Shared pin multiplexing by bus width and byte access type
`timescale 1ns/10ps
module pin_mux (
   input  wire smc_pin_pkg::bus_width_e   width_in,
   input  wire smc_pin_pkg::byte_access_e bat_in,
   input  wire logic [1:0]                addr_lo_in,
   input  wire logic [3:0]                byte_en_in,
   input  wire logic                      sel_act_in,
   input  wire logic                      wr_act_in,
   output logic                           lane0_out,
   output logic                           lane1_out,
   output logic                           lane2_out,
   output logic                           lane3_out,
   output logic                           we_out
);
   logic wide;
   logic bwrite;
   logic [3:0] bs_n;
   logic [3:0] wr_n;

   assign wide   = (width_in != smc_pin_pkg::WIDTH_8);
   assign bwrite = wide && (bat_in == smc_pin_pkg::BYTE_WRITE); // R18
   // Byte selects follow address timing; lane writes follow the write pulse
   assign bs_n = ~(byte_en_in & {4{sel_act_in}});
   assign wr_n = ~(byte_en_in & {4{wr_act_in}});

   assign lane0_out = !wide ? addr_lo_in[0] : (bwrite ? 1'b1 : bs_n[0]); // R19 R20
   assign we_out    = bwrite ? wr_n[0] : ~wr_act_in; // R20
   assign lane1_out = !wide ? 1'b1 : (bwrite ? wr_n[1] : bs_n[1]); // R20
   assign lane2_out = (width_in != smc_pin_pkg::WIDTH_32) ? addr_lo_in[1]
                      : (bwrite ? wr_n[2] : bs_n[2]); // R19
   assign lane3_out = (width_in != smc_pin_pkg::WIDTH_32) ? 1'b1
                      : (bwrite ? wr_n[3] : bs_n[3]); // R20
endmodule : pin_mux

// [rtl/smc_pin_pkg.sv]
// Constants and carrier types for the static memory pin interface
// Summary of operation
// [R1] Card slot select mirrors fourth chip select
// [R2] Card direction stable through whole transfer
// [R3] Flash assign enables glue on third region
// [R4] Read/write strobes reach flash enables when selected
// [R5] Flash enables drop outside third region
// [R6] Flash enables replace sixth, seventh selects
// [R7] Master avoids sixth/seventh region while assigned
// [R8] Address bits 22, 21 pick latch cycles
// [R9] Flash chip enable kept by general I/O
// [R10] Eight selects, 26-bit address, 32-bit data
// [R11] Active-low wait stretches current access
// [R12] Slow clock uses fixed slow waveforms
// [R13] Page-mode burst reads up to 32 bytes; here up to 32 beats, address stepping by 4 per beat
// [R14] Selects, strobes and wait active low
// [R15] Each select spans 64 Mbytes, aliasing
// [R16] Significant address bits follow bus width
// [R17] Per-select bus width 8, 16 or 32
// [R18] Wide buses use byte write or select
// [R19] Shared pins carry A0/A1 or lane strobes
// [R20] Unused lane strobes held inactive
// [R21] Idle: all selects and strobes high
package smc_pin_pkg;
   localparam int NUM_CS     = 8;
   localparam int ADDR_W     = 26;
   localparam int DATA_W     = 32;
   localparam int CS_W       = 3;
   localparam int CNT_W      = 6;
   localparam int PAGE_BYTES = 32;
   localparam int PAGE_W     = 5;
   localparam logic [CS_W-1:0] FLASH_CS = 3'h3;
   localparam logic [CS_W-1:0] CARD_CS  = 3'h4;
   localparam logic [CS_W-1:0] SIXTH_CS = 3'h6;
   localparam logic [CS_W-1:0] SEVENTH_CS = 3'h7;
   localparam int ALE_BIT    = 22;
   localparam int CLE_BIT    = 21;
   // Slow clock waveform: fixed two-cycle setup, pulse, hold
   localparam logic [CNT_W-1:0] SLOW_SETUP = 6'h01;
   localparam logic [CNT_W-1:0] SLOW_PULSE = 6'h01;
   localparam logic [CNT_W-1:0] SLOW_HOLD  = 6'h01;

   typedef enum logic [1:0] {
      WIDTH_8, WIDTH_16, WIDTH_32, WIDTH_RSVD
   } bus_width_e;

   typedef enum logic {
      BYTE_SELECT, BYTE_WRITE
   } byte_access_e;

   typedef struct packed {
      bus_width_e   bus_width_field;
      byte_access_e byte_access_type;
      logic [CNT_W-1:0] setup;
      logic [CNT_W-1:0] pulse;
      logic [CNT_W-1:0] hold;
   } per_select_mode_s;

   typedef struct packed {
      logic              valid;
      logic              write;
      logic [CS_W-1:0]   cs;
      logic [ADDR_W-1:0] addr;
      logic [3:0]        byte_en;
      logic [DATA_W-1:0] wdata;
      logic              page_burst;
      logic [PAGE_W-1:0] page_len;
   } access_req_s;

   typedef struct packed {
      logic [NUM_CS-1:0] chip_select_n;
      logic              read_strobe_n;
      logic              write_strobe_n;
      logic              lane0_pin;
      logic              lane1_pin;
      logic              lane2_pin;
      logic              lane3_pin;
      logic [ADDR_W-1:0] addr;
   } pins_s;
endpackage : smc_pin_pkg

// [rtl/static_memory_pin_interface.sv]
// Static memory controller pin front end with flash and card glue
`timescale 1ns/10ps
module static_memory_pin_interface (
   input  wire logic                                 core_clk_in,
   input  wire logic                                 rst_n_in,
   input  wire smc_pin_pkg::access_req_s             req_in,
   output logic                                      req_ready_out,
   output logic                                      rdata_valid_out,
   output logic [smc_pin_pkg::DATA_W-1:0]            rdata_out,
   output logic                                      done_out,
   input  wire smc_pin_pkg::per_select_mode_s [7:0]  mode_in,
   input  wire logic                                 flash_region_assign_in,
   input  wire logic                                 card_assign_in,
   input  wire logic                                 slow_clock_in,
   input  wire logic                                 wait_request_n_in,
   output logic [smc_pin_pkg::NUM_CS-1:0]            chip_select_n_out,
   output logic                                      card_slot_select_out,
   output logic                                      card_direction_out,
   output logic                                      read_strobe_n_out,
   output logic                                      write_strobe_n_out,
   output logic                                      lane0_out,
   output logic                                      lane1_out,
   output logic                                      lane2_out,
   output logic                                      lane3_out,
   output logic                                      flash_output_enable_out,
   output logic                                      flash_write_enable_out,
   output logic                                      flash_ale_out,
   output logic                                      flash_cle_out,
   output logic [smc_pin_pkg::ADDR_W-1:0]            addr_out,
   input  wire logic [smc_pin_pkg::DATA_W-1:0]       data_in,
   output logic [smc_pin_pkg::DATA_W-1:0]            data_out,
   output logic                                      data_oe_out
);
   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD} phase_e;

   phase_e                              phase_r;
   phase_e                              phase_nxt;
   smc_pin_pkg::access_req_s            cur_r;
   smc_pin_pkg::per_select_mode_s       cfg_r;
   logic [smc_pin_pkg::CNT_W-1:0]       cnt_r;
   logic [smc_pin_pkg::CNT_W-1:0]       cnt_nxt;
   logic [smc_pin_pkg::PAGE_W-1:0]      beats_r;
   logic [smc_pin_pkg::DATA_W-1:0]      rdata_r;
   logic                                rvalid_r;
   logic                                done_r;
   logic                                wait_n;

   // Significant address bits per width; lower bits forced to zero
   function automatic logic [smc_pin_pkg::ADDR_W-1:0] mask_addr(
      input logic [smc_pin_pkg::ADDR_W-1:0] a,
      input smc_pin_pkg::bus_width_e        w
   );
      logic [smc_pin_pkg::ADDR_W-1:0] r;
      r = a;
      case (w)
         smc_pin_pkg::WIDTH_16: r[0] = 1'b0;
         smc_pin_pkg::WIDTH_32: r[1:0] = 2'h0;
         default: r = a;
      endcase
      return r;
   endfunction : mask_addr

   // Timing selection: slow clock overrides programmed waveform
   function automatic logic [smc_pin_pkg::CNT_W-1:0] phase_len(
      input phase_e                        p,
      input smc_pin_pkg::per_select_mode_s m,
      input logic                          slow
   );
      logic [smc_pin_pkg::CNT_W-1:0] r;
      r = 6'h00;
      case (p)
         ST_SETUP: r = slow ? smc_pin_pkg::SLOW_SETUP : m.setup;
         ST_PULSE: r = slow ? smc_pin_pkg::SLOW_PULSE : m.pulse;
         ST_HOLD:  r = slow ? smc_pin_pkg::SLOW_HOLD  : m.hold;
         default:  r = 6'h00;
      endcase
      return r;
   endfunction : phase_len

   wait_sync u_wait (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .async_in    (wait_request_n_in),
      .level_out   (wait_n)
   );

   // Phase sequencing
   wire logic busy      = (phase_r != ST_IDLE);
   wire logic cnt_done  = (cnt_r == 6'h00);
   wire logic in_pulse  = (phase_r == ST_PULSE);
   wire logic stretched = in_pulse && !wait_n; // R11 R14
   wire logic more_beats = cur_r.page_burst && !cur_r.write && (beats_r != 5'h00); // R13
   wire logic accept    = !busy && req_in.valid;
   wire smc_pin_pkg::per_select_mode_s acc_cfg = mode_in[req_in.cs];

   assign req_ready_out = !busy;

   always_comb begin
      phase_nxt = phase_r;
      cnt_nxt   = cnt_r;
      case (phase_r)
         ST_IDLE: begin
            if (req_in.valid) begin
               phase_nxt = ST_SETUP;
               cnt_nxt   = phase_len(ST_SETUP, acc_cfg, slow_clock_in); // R12
            end
         end
         ST_SETUP: begin
            if (cnt_done) begin
               phase_nxt = ST_PULSE;
               cnt_nxt   = phase_len(ST_PULSE, cfg_r, slow_clock_in);
            end else begin
               cnt_nxt = cnt_r - 6'h01;
            end
         end
         ST_PULSE: begin
            if (stretched) begin
               cnt_nxt = cnt_r; // R11
            end else if (!cnt_done) begin
               cnt_nxt = cnt_r - 6'h01;
            end else if (more_beats) begin
               cnt_nxt = phase_len(ST_PULSE, cfg_r, slow_clock_in); // R13
            end else begin
               phase_nxt = ST_HOLD;
               cnt_nxt   = phase_len(ST_HOLD, cfg_r, slow_clock_in);
            end
         end
         ST_HOLD: begin
            if (cnt_done) begin
               phase_nxt = ST_IDLE;
            end else begin
               cnt_nxt = cnt_r - 6'h01;
            end
         end
         default: phase_nxt = ST_IDLE;
      endcase
   end

   wire logic pulse_end = in_pulse && cnt_done && !stretched;

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         phase_r <= ST_IDLE;
         cnt_r   <= 6'h00;
      end else begin
         phase_r <= phase_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // Captured access stays fixed for the whole transfer, except the address, which steps by 4 per burst beat
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         cur_r   <= '0;
         cfg_r   <= '0;
         beats_r <= 5'h00;
      end else if (accept) begin
         cur_r   <= req_in;
         cfg_r   <= acc_cfg;
         beats_r <= req_in.page_len;
      end else if (pulse_end && more_beats) begin
         cur_r.addr <= cur_r.addr + {{(smc_pin_pkg::ADDR_W-3){1'b0}}, 3'h4}; // R13
         beats_r    <= beats_r - 5'h01;
      end
   end

   // Read data captured on the cycle that ends the read pulse
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         rdata_r  <= 32'h0000_0000;
         rvalid_r <= 1'b0;
         done_r   <= 1'b0;
      end else begin
         rvalid_r <= pulse_end && !cur_r.write;
         done_r   <= (phase_r == ST_HOLD) && cnt_done;
         if (pulse_end && !cur_r.write) begin
            rdata_r <= data_in;
         end
      end
   end

   assign rdata_out       = rdata_r;
   assign rdata_valid_out = rvalid_r;
   assign done_out        = done_r;

   // Raw strobes; idle state leaves every select and strobe high
   wire logic rd_act = in_pulse && !cur_r.write;
   wire logic wr_act = in_pulse && cur_r.write;
   wire logic [smc_pin_pkg::NUM_CS-1:0] cs_raw_n =
      busy ? ~(8'h01 << cur_r.cs) : 8'hff; // R21 R10
   wire logic flash_mode = flash_region_assign_in; // R3
   wire logic flash_sel  = busy && (cur_r.cs == smc_pin_pkg::FLASH_CS); // R5
   wire logic flash_oe_n = !(flash_mode && flash_sel && rd_act); // R4 R5
   wire logic flash_we_n = !(flash_mode && flash_sel && wr_act); // R4 R5

   // Sixth and seventh select pins carry the flash strobes when assigned
   genvar gi;
   generate
      for (gi = 0; gi < smc_pin_pkg::NUM_CS; gi = gi + 1) begin : g_cs
         if (gi == int'(smc_pin_pkg::SIXTH_CS)) begin : g_six
            assign chip_select_n_out[gi] = flash_mode ? flash_oe_n : cs_raw_n[gi]; // R6
         end else if (gi == int'(smc_pin_pkg::SEVENTH_CS)) begin : g_sev
            assign chip_select_n_out[gi] = flash_mode ? flash_we_n : cs_raw_n[gi]; // R6
         end else begin : g_pl
            assign chip_select_n_out[gi] = cs_raw_n[gi]; // R14
         end
      end
   endgenerate

   assign flash_output_enable_out = flash_oe_n;
   assign flash_write_enable_out  = flash_we_n;
   // Latch enables come straight from the address bus
   assign flash_ale_out = addr_out[smc_pin_pkg::ALE_BIT]; // R8
   assign flash_cle_out = addr_out[smc_pin_pkg::CLE_BIT]; // R8

   // Card select is the fourth select waveform itself
   assign card_slot_select_out = card_assign_in ? cs_raw_n[smc_pin_pkg::CARD_CS] : 1'b1; // R1
   // Direction derives from the captured access, so it cannot move mid-transfer
   assign card_direction_out = busy ? !cur_r.write : 1'b1; // R2

   assign read_strobe_n_out = ~rd_act; // R14 R21
   // Address wraps within the 64 Mbyte window of each select
   assign addr_out = mask_addr(cur_r.addr, cfg_r.bus_width_field); // R15 R16

   pin_mux u_mux (
      .width_in   (cfg_r.bus_width_field), // R17
      .bat_in     (cfg_r.byte_access_type), // R18
      .addr_lo_in (cur_r.addr[1:0]),
      .byte_en_in (cur_r.byte_en),
      .sel_act_in (busy),
      .wr_act_in  (wr_act),
      .lane0_out  (lane0_out),
      .lane1_out  (lane1_out),
      .lane2_out  (lane2_out),
      .lane3_out  (lane3_out),
      .we_out     (write_strobe_n_out)
   );

   assign data_out    = cur_r.wdata;
   assign data_oe_out = busy && cur_r.write;
endmodule : static_memory_pin_interface

// [rtl/wait_sync.sv]
// Three-stage synchroniser for the external wait request
`timescale 1ns/10ps
module wait_sync (
   input  wire logic core_clk_in,
   input  wire logic rst_n_in,
   input  wire logic async_in,
   output logic      level_out
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         s1_r      <= 1'b1;
         s2_r      <= 1'b1;
         s3_r      <= 1'b1;
         level_out <= 1'b1;
      end else begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         // Only take a change once stages two and three agree
         if (s2_r == s3_r) begin
            level_out <= s3_r;
         end
      end
   end
endmodule : wait_sync
